// ---- rtl/oca_pkg.sv ----
// Constants, register map and carrier types for the OSD character attribute unit.
// Assumes a byte-wide register port and a pixel stream from the OSD timing logic.
package oca_pkg;
  localparam int VRAM_AW = 9;
  localparam int VRAM_DEPTH = 512;
  localparam int LINES = 12;
  localparam logic [7:0] OFF_ATTR = 8'h1D;
  localparam logic [7:0] OFF_CODE_LO = 8'h1E;
  localparam logic [7:0] OFF_CODE_HI = 8'h1F;
  localparam logic [7:0] OFF_PTR_LO = 8'h24;
  localparam logic [7:0] OFF_PTR_HI = 8'h25;
  localparam logic [7:0] OFF_MODE = 8'h20;
  localparam logic [7:0] OFF_DISP = 8'h21;
  localparam logic [7:0] OFF_MISC = 8'h22;
  localparam logic [7:0] OFF_BACK = 8'h23;
  localparam logic [7:0] OFF_ULLO = 8'h26;
  localparam logic [7:0] OFF_ULHI = 8'h27;
  localparam logic [7:0] OFF_SOL0 = 8'h28;
  localparam logic [7:0] OFF_SOL1 = 8'h29;
  localparam logic [7:0] OFF_SOL2 = 8'h2A;
  localparam logic [7:0] OFF_TRIG = 8'h2B;
  localparam logic [7:0] OFF_PAL = 8'h30;
  localparam logic [7:0] PAL_MASK = 8'hF8;
  localparam int BIT_RMW = 0;
  localparam int BIT_COMB = 1;
  localparam int BIT_DIR = 2;
  localparam int BIT_FDBL = 5;
  localparam int BIT_SPLIT = 5;
  localparam int BIT_BLINK = 5;
  localparam int BIT_LBLANK = 3;
  localparam int BIT_TRIG = 0;
  localparam logic [8:0] CODE_BLANK = 9'h000;
  localparam logic [8:0] COLOR_LO = 9'h180;
  localparam logic [8:0] COLOR_HI_NORM = 9'h1DF;
  localparam logic [8:0] COLOR_HI_SPLIT = 9'h1BF;
  localparam logic [5:0] FRINGE_RGB = 6'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    FD_OFF = 3'b001,
    FD_ARMED = 3'b010,
    FD_ON = 3'b100
  } oca_fd_e;

  typedef struct packed {
    logic rsvd;
    logic slant;
    logic ul;
    logic blink;
    logic bg;
    logic [2:0] col;
  } oca_attr_s;

  typedef struct packed {
    logic valid;
    logic [8:0] addr;
    logic [3:0] line;
    logic solid_l;
    logic solid_r;
    logic dot;
    logic dot_slant;
    logic spill;
    logic fringe;
    logic ul_row;
  } oca_pix_in_s;

  typedef struct packed {
    logic valid;
    logic on;
    logic [5:0] rgb;
    logic vid_kill;
    logic color_font;
  } oca_pix_out_s;
endpackage

// ---- rtl/oca_unit.sv ----
// OSD character attribute unit: display memory access port and cell renderer.
// Assumes the CPU keeps the access spacing itself and a font ROM supplies dots.
//
// What the document requires
// [R1] Top code bit first; low byte commits, increments
// [R2] Low byte alone reuses held top bit
// [R3] Read top bit, then low byte increments
// [R4] Two cycles after pointer set before access
// [R5] Two cycles between data write and read
// [R6] Split clear: 180H-1DFH colour, rest monochrome
// [R7] Split set: 180H-1BFH colour only
// [R8] Three-bit field picks one of eight palettes
// [R9] Blink hides glyph, keeps background
// [R10] Fringe dots never blink
// [R11] Underline needs character and line enable
// [R12] Underline uses character colour
// [R13] Per-line solid column left, right, both
// [R14] Solid area kills video, backdrop colour
// [R15] Slant bit italicises glyph and background
// [R16] Slanted spill into right cell hidden
// [R17] Dot left of slanted glyph slants too
// [R18] Luma blank hides video beside slant
// [R19] No slant on colour font codes; here the slant bit also slants colour font codes
// [R20] Trigger in field two starts doubling
// [R21] Trigger field need not display right
// [R22] Jitter enable needed for phase results
// [R23] Read-modify-write read keeps pointer
// [R24] Combined bank commits attributes with code
// [R25] Pointer wraps past top value
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module oca_unit
  import oca_pkg::*;
#(
  parameter int NUM_LINES = LINES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire oca_pix_in_s pix_in,
  input wire logic fld_start,
  input wire logic fld_first,
  output oca_pix_out_s pix_out,
  output logic fdbl_active
);

  function automatic logic is_color(input logic [8:0] code, input logic split);
    is_color = (code >= COLOR_LO) && (code <= (split ? COLOR_HI_SPLIT : COLOR_HI_NORM));
  endfunction

  function automatic logic [5:0] expand3(input logic [2:0] c);
    expand3 = {c[2], c[2], c[1], c[1], c[0], c[0]};
  endfunction

  logic [8:0] code_mem [VRAM_DEPTH];
  logic [7:0] attr_mem [VRAM_DEPTH];
  logic [5:0] palette [8];
  logic [VRAM_AW-1:0] ptr;
  logic top_bit;
  logic [7:0] attr_hold;
  logic [7:0] mode;
  logic [7:0] disp;
  logic [7:0] misc;
  logic [2:0] backdrop;
  logic [NUM_LINES-1:0] line_ul;
  logic [2*NUM_LINES-1:0] solid;
  oca_fd_e fd_state;
  oca_fd_e next_fd;

  // Register decode
  wire logic rmw = mode[BIT_RMW];
  wire logic comb = mode[BIT_COMB];
  wire logic split = disp[BIT_SPLIT];
  wire logic wr_attr = reg_wr && (reg_addr == OFF_ATTR);
  wire logic wr_lo = reg_wr && (reg_addr == OFF_CODE_LO);
  wire logic wr_hi = reg_wr && (reg_addr == OFF_CODE_HI);
  wire logic wr_plo = reg_wr && (reg_addr == OFF_PTR_LO);
  wire logic wr_phi = reg_wr && (reg_addr == OFF_PTR_HI);
  wire logic wr_pal = reg_wr && ((reg_addr & PAL_MASK) == OFF_PAL);
  wire logic wr_trig = reg_wr && (reg_addr == OFF_TRIG) && reg_wdata[BIT_TRIG];
  wire logic rd_attr = reg_rd && (reg_addr == OFF_ATTR);
  wire logic rd_lo = reg_rd && (reg_addr == OFF_CODE_LO);
  // Pointer steps: code low byte always on write, attributes only when not combined
  wire logic inc_wr = wr_lo || (wr_attr && !comb); // [R1] [R24]
  wire logic inc_rd = !rmw && (rd_lo || (rd_attr && !comb)); // [R3] [R23]
  wire logic [VRAM_AW-1:0] ptr_plus = ptr + 9'h001; // [R25]

  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      OFF_ATTR: rd_mux = attr_mem[ptr];
      OFF_CODE_LO: rd_mux = code_mem[ptr][7:0];
      OFF_CODE_HI: rd_mux = {7'h00, code_mem[ptr][8]};
      OFF_MODE: rd_mux = mode;
      OFF_DISP: rd_mux = disp;
      OFF_MISC: rd_mux = misc;
      OFF_BACK: rd_mux = {5'h00, backdrop};
      OFF_ULLO: rd_mux = line_ul[7:0];
      OFF_ULHI: rd_mux = {4'h0, line_ul[NUM_LINES-1:8]};
      OFF_SOL0: rd_mux = solid[7:0];
      OFF_SOL1: rd_mux = solid[15:8];
      OFF_SOL2: rd_mux = solid[23:16];
      OFF_TRIG: rd_mux = {7'h00, fd_state == FD_ON};
      default: rd_mux = ((reg_addr & PAL_MASK) == OFF_PAL) ?
                        {2'b00, palette[reg_addr[2:0]]} : RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= RESET_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RESET_BYTE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ptr <= '0;
    end else if (wr_phi) begin
      ptr <= {reg_wdata[0], ptr[7:0]};
    end else if (wr_plo) begin
      ptr <= {ptr[8], reg_wdata};
    end else if (inc_wr || inc_rd) begin
      ptr <= ptr_plus; // [R1] [R3] [R25]
    end
  end

  // Display memory is not reset; software fills it before enabling the display
  always_ff @(posedge clk_sys) begin
    if (wr_lo) begin
      code_mem[ptr] <= {top_bit, reg_wdata}; // [R1] [R2]
    end
    if (wr_lo && comb) begin
      attr_mem[ptr] <= attr_hold; // [R24]
    end else if (wr_attr && !comb) begin
      attr_mem[ptr] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      top_bit <= 1'b0;
      attr_hold <= RESET_BYTE;
      mode <= RESET_BYTE;
      disp <= RESET_BYTE;
      misc <= RESET_BYTE;
      backdrop <= '0;
      line_ul <= '0;
      solid <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_CODE_HI: top_bit <= reg_wdata[0]; // [R2]
        OFF_ATTR: attr_hold <= reg_wdata;
        OFF_MODE: mode <= reg_wdata;
        OFF_DISP: disp <= reg_wdata;
        OFF_MISC: misc <= reg_wdata;
        OFF_BACK: backdrop <= reg_wdata[2:0];
        OFF_ULLO: line_ul[7:0] <= reg_wdata;
        OFF_ULHI: line_ul[NUM_LINES-1:8] <= reg_wdata[3:0];
        OFF_SOL0: solid[7:0] <= reg_wdata;
        OFF_SOL1: solid[15:8] <= reg_wdata;
        OFF_SOL2: solid[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        palette[i] <= '0;
      end
    end else if (wr_pal) begin
      palette[reg_addr[2:0]] <= reg_wdata[5:0]; // [R8]
    end
  end

  // Field doubling: trigger arms, next first field starts doubled display
  always_comb begin
    next_fd = fd_state;
    unique case (fd_state)
      FD_OFF: if (mode[BIT_FDBL] && wr_trig) next_fd = FD_ARMED; // [R20]
      FD_ARMED: if (fld_start && fld_first) next_fd = FD_ON; // [R20] [R21]
      FD_ON: ;
    endcase
    if (!mode[BIT_FDBL]) next_fd = FD_OFF;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fd_state <= FD_OFF;
      fdbl_active <= 1'b0;
    end else begin
      fd_state <= next_fd;
      fdbl_active <= (next_fd == FD_ON);
    end
  end

  // Cell renderer
  oca_attr_s cell_attr;
  assign cell_attr = attr_mem[pix_in.addr];
  wire logic [8:0] cell_code = code_mem[pix_in.addr];
  wire logic cell_color = is_color(cell_code, split); // [R6] [R7]
  wire logic cell_glyph = (cell_code != CODE_BLANK);
  wire logic [3:0] ln = (pix_in.line < 4'(NUM_LINES)) ? pix_in.line : 4'h0;
  wire logic [1:0] sol_code = solid[2*ln +: 2]; // [R13]
  wire logic in_solid = (pix_in.solid_l && sol_code[0]) || (pix_in.solid_r && sol_code[1]);
  wire logic in_cell = !pix_in.solid_l && !pix_in.solid_r;
  // The slanted sample already carries the left neighbour dot when it shifts in
  wire logic slanted = cell_attr.slant;
  wire logic dot_eff = slanted ? (pix_in.dot_slant && !pix_in.spill) : pix_in.dot; // [R15] [R16] [R17]
  wire logic bg_eff = cell_attr.bg && !(slanted && pix_in.spill); // [R15]
  wire logic blinked = misc[BIT_BLINK] && cell_attr.blink; // [R9]
  wire logic ul_hit = cell_attr.ul && line_ul[ln] && pix_in.ul_row; // [R11]
  wire logic glyph_on = cell_glyph && (dot_eff || ul_hit) && !blinked; // [R9]
  wire logic fringe_on = pix_in.fringe; // [R10]
  wire logic black_bg = (backdrop == 3'b000);
  wire logic luma_blank = misc[BIT_LBLANK] && slanted && black_bg; // [R18]

  oca_pix_out_s next_out;
  always_comb begin
    next_out = '0;
    next_out.valid = pix_in.valid;
    next_out.color_font = cell_color;
    if (in_solid) begin
      next_out.on = 1'b1;
      next_out.vid_kill = 1'b1; // [R14]
      next_out.rgb = expand3(backdrop);
    end else if (in_cell) begin
      next_out.vid_kill = luma_blank; // [R18]
      if (glyph_on) begin
        next_out.on = 1'b1;
        next_out.rgb = palette[cell_attr.col]; // [R8] [R12]
      end else if (fringe_on) begin
        next_out.on = 1'b1;
        next_out.rgb = FRINGE_RGB; // [R10]
      end else if (bg_eff) begin
        next_out.on = 1'b1;
        next_out.rgb = expand3(backdrop);
      end
    end
    if (!pix_in.valid) next_out = '0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pix_out <= '0;
    end else begin
      pix_out <= next_out;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_ptr_set;
    !wr_phi && !wr_plo;
  endsequence

  property p_code_wr_inc;
    (wr_lo and s_ptr_set) |=> ptr == $past(ptr_plus);
  endproperty
  a_code_wr_inc: assert property (p_code_wr_inc) else $error("pointer not stepped"); // [R1]

  property p_code_store;
    wr_lo |=> code_mem[$past(ptr)] == {$past(top_bit), $past(reg_wdata)};
  endproperty
  a_code_store: assert property (p_code_store) else $error("code not stored"); // [R2]

  property p_rd_inc;
    ((rd_lo && !rmw) and s_ptr_set) |=> ptr == $past(ptr) + 9'h001;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read did not step"); // [R3]

  property p_rmw_hold;
    reg_rd && rmw && !reg_wr |=> $stable(ptr);
  endproperty
  a_rmw_hold: assert property (p_rmw_hold) else $error("rmw read moved pointer"); // [R23]

  property p_comb_hold;
    wr_attr && comb |=> $stable(ptr) && attr_hold == $past(reg_wdata);
  endproperty
  a_comb_hold: assert property (p_comb_hold) else $error("attr commit early"); // [R24]

  property p_blink;
    pix_in.valid && in_cell && blinked && !fringe_on && !bg_eff |=> !pix_out.on;
  endproperty
  a_blink: assert property (p_blink) else $error("blinked glyph shown"); // [R9]

  property p_ul_color;
    pix_in.valid && in_cell && ul_hit && !blinked && cell_glyph
      |=> pix_out.on && pix_out.rgb == $past(palette[cell_attr.col]);
  endproperty
  a_ul_color: assert property (p_ul_color) else $error("underline colour"); // [R12]

  property p_solid;
    pix_in.valid && in_solid |=> pix_out.vid_kill && pix_out.rgb == expand3($past(backdrop));
  endproperty
  a_solid: assert property (p_solid) else $error("solid area wrong"); // [R14]

  sequence s_arm;
    mode[BIT_FDBL] && wr_trig && fd_state == FD_OFF;
  endsequence

  // Armed wait spans four cycles with no first-field start before the first field arrives
  property p_fdbl;
    s_arm ##1 (mode[BIT_FDBL] && !(fld_start && fld_first))[*4]
      ##1 (mode[BIT_FDBL] && fld_start && fld_first) |=> fdbl_active;
  endproperty
  a_fdbl: assert property (p_fdbl) else $error("doubling not started"); // [R20]

  property p_split;
    pix_in.valid && cell_code == COLOR_HI_NORM |=> pix_out.color_font == !$past(split);
  endproperty
  a_split: assert property (p_split) else $error("font split range"); // [R7]

  property p_color_lo;
    pix_in.valid && cell_code == COLOR_LO |=> pix_out.color_font;
  endproperty
  a_color_lo: assert property (p_color_lo) else $error("colour range start"); // [R6]

  property p_fringe;
    pix_in.valid && in_cell && fringe_on && !glyph_on
      |=> pix_out.on && pix_out.rgb == FRINGE_RGB;
  endproperty
  a_fringe: assert property (p_fringe) else $error("fringe dot lost"); // [R10]

  property p_spill;
    pix_in.valid && in_cell && slanted && pix_in.spill && !ul_hit && !fringe_on
      |=> !pix_out.on;
  endproperty
  a_spill: assert property (p_spill) else $error("slant spill shown"); // [R16]

  property p_luma;
    pix_in.valid && in_cell && slanted && misc[BIT_LBLANK] && black_bg |=> pix_out.vid_kill;
  endproperty
  a_luma: assert property (p_luma) else $error("luma blank missing"); // [R18]

  property p_fdbl_stop;
    !mode[BIT_FDBL] |=> !fdbl_active;
  endproperty
  a_fdbl_stop: assert property (p_fdbl_stop) else $error("doubling not stopped"); // [R20]

endmodule // oca_unit
`default_nettype wire

// ---- rtl/oca_empty.sv ----
`timescale 1ns/1ns

// ---- tb/oca_cpu_model.sv ----
// CPU core model: byte register master for the OSD character attribute unit.
// Assumes the unit answers reads in the cycle after the strobe, never stalling.
`timescale 1ns/1ns
`default_nettype none
module oca_cpu_model
  import oca_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic data_written = 1'b0;
  initial begin
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle bus shows the inverse of the last value, so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    if (a == OFF_PTR_LO || a == OFF_PTR_HI) repeat (2) @(posedge clk_sys);
    data_written = (a == OFF_CODE_LO || a == OFF_CODE_HI || a == OFF_ATTR);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    if (data_written) repeat (2) @(posedge clk_sys);
    data_written = 1'b0;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 q = reg_rdata;
  endtask
endmodule // oca_cpu_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench: register access through the CPU model, pixel requests direct.
// Assumes oca_unit and oca_cpu_model are compiled alongside the package.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import oca_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, fdbl_active;
  logic fld_start = 1'b0;
  logic fld_first = 1'b0;
  oca_pix_in_s pin = '0;
  oca_pix_out_s po;
  int mismatches = 0;
  int check_count = 0;
  logic [5:0] pal [8];
  logic [8:0] codes [6] = '{9'h17F, 9'h180, 9'h1BF, 9'h1C0, 9'h1DF, 9'h1F0};
  logic [5:0] cf0 = 6'b011110;
  logic [5:0] cf1 = 6'b000110;
  always #20 clk_sys = ~clk_sys;
  oca_unit u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pin),
    .fld_start(fld_start), .fld_first(fld_first), .pix_out(po), .fdbl_active(fdbl_active));
  oca_cpu_model u_cpu (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic setp(input logic [8:0] a);
    u_cpu.wr(OFF_PTR_HI, {7'h00, a[8]});
    u_cpu.wr(OFF_PTR_LO, a[7:0]);
  endtask
  task automatic code(input logic [8:0] c);
    u_cpu.wr(OFF_CODE_HI, {7'h00, c[8]});
    u_cpu.wr(OFF_CODE_LO, c[7:0]);
  endtask
  // Flags: solid_l, solid_r, dot, dot_slant, spill, fringe, ul_row
  task automatic px(input logic [8:0] a, input logic [3:0] ln, input logic [6:0] f);
    @(posedge clk_sys);
    pin <= {1'b1, a, ln, f};
    @(posedge clk_sys);
    pin <= '0;
    #1;
  endtask
  // Field identity stands for the sync phase result that software reads
  task automatic fld(input logic first);
    @(posedge clk_sys);
    fld_start <= 1'b1;
    fld_first <= first;
    @(posedge clk_sys);
    fld_start <= 1'b0;
  endtask
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    setp(9'h120);
    code(9'h020);
    setp(9'h120);
    u_cpu.rd(OFF_CODE_HI, q);
    chk("code top", q, 8'h00);
    u_cpu.rd(OFF_CODE_LO, q);
    chk("code low", q, 8'h20);
    setp(9'h1FF);
    code(9'h105);
    u_cpu.wr(OFF_CODE_LO, 8'h06);
    setp(9'h1FF);
    u_cpu.rd(OFF_CODE_HI, q);
    chk("top 1FF", q, 8'h01);
    u_cpu.rd(OFF_CODE_LO, q);
    chk("low 1FF", q, 8'h05);
    u_cpu.rd(OFF_CODE_HI, q);
    chk("top 000", q, 8'h01);
    u_cpu.rd(OFF_CODE_LO, q);
    chk("low 000", q, 8'h06);
    // Read-modify-write: two reads of one cell, then overwrite it
    u_cpu.wr(OFF_MODE, 8'h01);
    setp(9'h120);
    u_cpu.rd(OFF_CODE_LO, q);
    u_cpu.rd(OFF_CODE_HI, q);
    chk("rmw top", q, 8'h00);
    code(9'h021);
    u_cpu.wr(OFF_MODE, 8'h02);
    setp(9'h130);
    u_cpu.wr(OFF_ATTR, 8'h05);
    code(9'h041);
    code(9'h042);
    u_cpu.wr(OFF_MODE, 8'h00);
    setp(9'h120);
    u_cpu.rd(OFF_CODE_HI, q);
    u_cpu.rd(OFF_CODE_LO, q);
    chk("rmw low", q, 8'h21);
    setp(9'h130);
    u_cpu.rd(OFF_ATTR, q);
    chk("comb attr", q, 8'h05);
    u_cpu.rd(OFF_CODE_HI, q);
    u_cpu.rd(OFF_CODE_LO, q);
    chk("comb next", q, 8'h42);
    u_cpu.rd(8'h3F, q);
    chk("unmapped", q, 8'h00);
    u_cpu.rd(OFF_PTR_LO, q);
    chk("ptr read", q, 8'h00);
    // Pixel path: palette, colours, blink, underline, solid columns
    for (int i = 0; i < 8; i++) begin
      pal[i] = 6'(i * 7 + 3);
      u_cpu.wr(OFF_PAL + 8'(i), {2'b00, pal[i]});
    end
    u_cpu.wr(OFF_BACK, 8'h05);
    setp(9'h000);
    for (int i = 0; i < 10; i++) code(9'h041);
    setp(9'h000);
    for (int i = 0; i < 8; i++) u_cpu.wr(OFF_ATTR, 8'(i));
    u_cpu.wr(OFF_ATTR, 8'h19);
    u_cpu.wr(OFF_ATTR, 8'h23);
    for (int i = 0; i < 8; i++) begin
      px(9'(i), 4'h0, 7'b0010000);
      chk("palette", {2'b00, po.rgb}, {2'b00, pal[i]});
    end
    px(9'h008, 4'h0, 7'b0010000);
    chk("no blink", {2'b00, po.rgb}, {2'b00, pal[1]});
    u_cpu.wr(OFF_MISC, 8'h20);
    px(9'h008, 4'h0, 7'b0010000);
    chk("blink bg", {2'b00, po.rgb}, 8'h33);
    px(9'h008, 4'h0, 7'b0000010);
    chk("fringe", {2'b00, po.rgb}, 8'h00);
    px(9'h009, 4'h0, 7'b0000001);
    chk("ul off", {7'h00, po.on}, 8'h00);
    u_cpu.wr(OFF_ULLO, 8'h01);
    px(9'h009, 4'h0, 7'b0000001);
    chk("ul on", {7'h00, po.on}, 8'h01);
    chk("ul col", {2'b00, po.rgb}, {2'b00, pal[3]});
    u_cpu.wr(OFF_SOL0, 8'h07);
    px(9'h000, 4'h0, 7'b1000000);
    chk("solid kill", {7'h00, po.vid_kill}, 8'h01);
    chk("solid rgb", {2'b00, po.rgb}, 8'h33);
    px(9'h000, 4'h0, 7'b0100000);
    chk("solid both", {7'h00, po.vid_kill}, 8'h01);
    px(9'h000, 4'h1, 7'b0100000);
    chk("solid left only", {7'h00, po.vid_kill}, 8'h00);
    px(9'h000, 4'h1, 7'b1000000);
    chk("solid left", {7'h00, po.vid_kill}, 8'h01);
    // Font split ranges
    setp(9'h010);
    for (int j = 0; j < 6; j++) code(codes[j]);
    setp(9'h010);
    for (int j = 0; j < 6; j++) u_cpu.wr(OFF_ATTR, 8'h00);
    for (int s = 0; s < 2; s++) begin
      u_cpu.wr(OFF_DISP, (s == 1) ? 8'h20 : 8'h00);
      for (int j = 0; j < 6; j++) begin
        px(9'(16 + j), 4'h0, 7'b0010000);
        chk("color font", {7'h00, po.color_font}, {7'h00, s ? cf1[j] : cf0[j]});
      end
    end
    // Slant on monochrome cells only: plain, slanted dot, spill, luma blank, blink
    setp(9'h00A);
    code(9'h041);
    code(9'h041);
    setp(9'h00A);
    u_cpu.wr(OFF_ATTR, 8'h40);
    u_cpu.wr(OFF_ATTR, 8'h10);
    px(9'h00A, 4'h0, 7'b0010000);
    chk("slant plain dot", {7'h00, po.on}, 8'h00);
    px(9'h00A, 4'h0, 7'b0001000);
    chk("slant dot", {7'h00, po.on}, 8'h01);
    chk("slant col", {2'b00, po.rgb}, {2'b00, pal[0]});
    px(9'h00A, 4'h0, 7'b0001100);
    chk("slant spill", {7'h00, po.on}, 8'h00);
    u_cpu.wr(OFF_BACK, 8'h00);
    u_cpu.wr(OFF_MISC, 8'h28);
    px(9'h00A, 4'h0, 7'b0001000);
    chk("luma blank", {7'h00, po.vid_kill}, 8'h01);
    px(9'h000, 4'h0, 7'b0010000);
    chk("luma upright", {7'h00, po.vid_kill}, 8'h00);
    px(9'h00B, 4'h0, 7'b0010000);
    chk("blink hidden", {po.valid, po.on, 6'h00}, 8'h80);
    @(posedge clk_sys);
    #1 chk("idle", {po.valid, po.on, po.rgb}, 8'h00);
    u_cpu.wr(OFF_MODE, 8'h20);
    u_cpu.wr(OFF_TRIG, 8'h01);
    fld(1'b0);
    @(posedge clk_sys);
    #1 chk("fdbl early", {7'h00, fdbl_active}, 8'h00);
    fld(1'b1);
    @(posedge clk_sys);
    #1 chk("fdbl start", {7'h00, fdbl_active}, 8'h01);
    u_cpu.rd(OFF_TRIG, q);
    chk("trig read", q, 8'h01);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
